// ### inc/smsr_pkg.sv
package smsr_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] MODE_SELECT_ADDR = 8'h04;
  localparam logic [7:0] MODE_SELECT_RESET = 8'h80;
  localparam logic [7:0] MODE_SELECT_WMASK = 8'hBF;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FAILSAFE_LOW_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int CRC_CLEAR_BIT = 5;
  localparam int PIXEL_GATING_BIT = 4;
  localparam int LEGACY_OVERRIDE_BIT = 3;
  localparam int LEGACY_SELECT_BIT = 2;
  localparam int RANGE_OVERRIDE_BIT = 1;
  localparam int RANGE_SELECT_BIT = 0;

  // ************************************************************
  // widths and synchroniser depth
  // ************************************************************
  localparam int PIXEL_WIDTH = 24;
  localparam int SYNC_STAGES = 2;
endpackage

// ### hdl/smsr_sync.sv
`timescale 1ns/1ps
module smsr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ### hdl/smsr_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bit 7 picks failsafe level; 0 high, 1 low; resets to 1.
// - bit 5 set holds crc error counters clear; never self-clears.
// - bit 4 set gates pixel data with enable in legacy/unprotected use.
// - bit 3 picks legacy mode source: 0 pin, 1 register bit 2.
// - bit 2 under register source: 0 normal, 1 legacy compatible.
// - bit 1 picks clock range source: 0 pin, 1 register bit 0.
// - bit 0: 0 high range 15-85MHz, 1 low range 5-15MHz.
module smsr_top #(
  parameter int PIXEL_WIDTH = smsr_pkg::PIXEL_WIDTH
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_legacy_compat_pin,
  input wire logic i_clock_range_pin,
  input wire logic i_peer_unprotected,
  input wire logic i_pixel_enable,
  input wire logic [PIXEL_WIDTH-1:0] i_pixel_data,
  output logic [PIXEL_WIDTH-1:0] o_pixel_data,
  output logic o_failsafe_low,
  output logic o_crc_count_clear,
  output logic o_pixel_gating_by_enable,
  output logic o_legacy_compat_select,
  output logic o_slow_clock_range_select
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ************************************************************
  // mode pins
  // ************************************************************
  // pins are asynchronous straps, so they pass two flops first
  logic [1:0] pins_sync;

  smsr_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_async({i_legacy_compat_pin, i_clock_range_pin}),
    .o_sync(pins_sync)
  );

  // ************************************************************
  // decoding helpers
  // ************************************************************
  // true when the bus addresses the mode select register
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == smsr_pkg::MODE_SELECT_ADDR);
  endfunction

  // override set: the register bit wins, else the synced pin
  function automatic logic pick_source(
    input logic override,
    input logic reg_value,
    input logic pin_value
  );
    if (override) begin
      pick_source = reg_value;
    end else begin
      pick_source = pin_value;
    end
  endfunction

  // ************************************************************
  // mode select register
  // ************************************************************
  logic [7:0] mode_select;
  logic wr_hit;
  logic rd_hit;

  assign wr_hit = i_reg_wr && addr_hit(i_reg_addr);
  assign rd_hit = i_reg_rd && addr_hit(i_reg_addr);

  // bits outside the write mask keep their reset value, which is
  // how the reserved bit stays at zero
  for (genvar b = 0; b < 8; b++) begin : g_mode_bit
    always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
        mode_select[b] <= smsr_pkg::MODE_SELECT_RESET[b];
      end else if (wr_hit && smsr_pkg::MODE_SELECT_WMASK[b]) begin
        mode_select[b] <= i_reg_wdata[b];
      end
    end
  end

  // read data held until the next read; unmapped reads return zero
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= smsr_pkg::UNMAPPED_RDATA;
    end else if (rd_hit) begin
      o_reg_rdata <= mode_select & smsr_pkg::MODE_SELECT_WMASK;
    end else if (i_reg_rd) begin
      o_reg_rdata <= smsr_pkg::UNMAPPED_RDATA;
    end
  end

  // ************************************************************
  // pin copies
  // ************************************************************
  // pins only matter while their override bit is clear
  logic legacy_pin;
  logic range_pin;

  assign legacy_pin = pins_sync[1];
  assign range_pin = pins_sync[0];

  // ************************************************************
  // effective selections
  // ************************************************************
  logic next_legacy;
  logic next_slow;

  assign next_legacy = pick_source(
    mode_select[smsr_pkg::LEGACY_OVERRIDE_BIT],
    mode_select[smsr_pkg::LEGACY_SELECT_BIT],
    legacy_pin
  );

  assign next_slow = pick_source(
    mode_select[smsr_pkg::RANGE_OVERRIDE_BIT],
    mode_select[smsr_pkg::RANGE_SELECT_BIT],
    range_pin
  );

  // ************************************************************
  // registered outputs, one flop per concern
  // ************************************************************
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_failsafe_low <=
        smsr_pkg::MODE_SELECT_RESET[smsr_pkg::FAILSAFE_LOW_BIT];
    end else begin
      o_failsafe_low <= mode_select[smsr_pkg::FAILSAFE_LOW_BIT];
    end
  end

  // level, not pulse: counters stay cleared while the bit is set
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_crc_count_clear <=
        smsr_pkg::MODE_SELECT_RESET[smsr_pkg::CRC_CLEAR_BIT];
    end else begin
      o_crc_count_clear <= mode_select[smsr_pkg::CRC_CLEAR_BIT];
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_pixel_gating_by_enable <=
        smsr_pkg::MODE_SELECT_RESET[smsr_pkg::PIXEL_GATING_BIT];
    end else begin
      o_pixel_gating_by_enable <= mode_select[smsr_pkg::PIXEL_GATING_BIT];
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_legacy_compat_select <= 1'b0;
    end else begin
      o_legacy_compat_select <= next_legacy;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_slow_clock_range_select <= 1'b0;
    end else begin
      o_slow_clock_range_select <= next_slow;
    end
  end

  // ************************************************************
  // pixel gating
  // ************************************************************
  logic gate_now;

  // uses the live selection so gating matches the current mode
  assign gate_now = mode_select[smsr_pkg::PIXEL_GATING_BIT]
    && (next_legacy || i_peer_unprotected) && !i_pixel_enable;

  // a gated beat is zeroed, not held, so stale colour never leaks
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_pixel_data <= '0;
    end else if (gate_now) begin
      o_pixel_data <= '0;
    end else begin
      o_pixel_data <= i_pixel_data;
    end
  end
endmodule

// ### tb/smsr_top_sva.sv
`timescale 1ns/1ps
module smsr_top_sva #(parameter int PIXEL_WIDTH = 24) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_pixel_enable,
  input wire logic [PIXEL_WIDTH-1:0] i_pixel_data,
  input wire logic [PIXEL_WIDTH-1:0] o_pixel_data,
  input wire logic o_failsafe_low,
  input wire logic o_crc_count_clear,
  input wire logic o_pixel_gating_by_enable,
  input wire logic o_legacy_compat_select,
  input wire logic o_slow_clock_range_select
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_wr;
    i_reg_wr && i_reg_addr == 8'h04;
  endsequence
  property p_bit(int b, logic o);
    logic v;
    (s_wr, v = i_reg_wdata[b]) |-> ##2 o == v;
  endproperty
  property p_src(int s, int b, logic o);
    logic v;
    (s_wr ##0 i_reg_wdata[s], v = i_reg_wdata[b]) |-> ##2 o == v;
  endproperty
  a_failsafe_level: assert property (p_bit(7, o_failsafe_low))
    else $error("failsafe");
  a_crc_clear: assert property (p_bit(5, o_crc_count_clear))
    else $error("crc clear");
  a_crc_no_self: assert property ($fell(o_crc_count_clear)
    |-> $past(i_reg_wr, 2)) else $error("crc self clear");
  a_gate_bit: assert property (p_bit(4, o_pixel_gating_by_enable))
    else $error("gating");
  a_legacy_reg: assert property (p_src(3, 2, o_legacy_compat_select))
    else $error("legacy");
  a_range_reg: assert property (p_src(1, 0, o_slow_clock_range_select))
    else $error("range");
  // internal reset lags two edges, so skip three after release
  a_pixel_pass: assert property (i_pixel_enable && $past(I_RST_N)
    && $past(I_RST_N, 2) && $past(I_RST_N, 3)
    |=> o_pixel_data == $past(i_pixel_data)) else $error("pixel");
  a_reserved_zero: assert property (i_reg_rd |=> !o_reg_rdata[6])
    else $error("reserved");
endmodule
bind smsr_top smsr_top_sva #(.PIXEL_WIDTH(PIXEL_WIDTH)) smsr_top_sva_inst (.*);

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic I_CLK = 0, I_RST_N = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic i_legacy_compat_pin = 0, i_clock_range_pin = 0;
  logic i_peer_unprotected = 0, i_pixel_enable = 1;
  logic [7:0] i_reg_addr = 8'h04, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [23:0] i_pixel_data = 24'h000000, o_pixel_data;
  logic o_failsafe_low, o_crc_count_clear, o_pixel_gating_by_enable;
  logic o_legacy_compat_select, o_slow_clock_range_select;
  logic [4:0] outs;
  int failures = 0, total_checks = 0;
  // write, pins, readback, outputs
  logic [22:0] rows [6] = '{{8'hFF, 2'h0, 8'hBF, 5'h1F},
    {8'h00, 2'h3, 8'h00, 5'h03}, {8'h0A, 2'h0, 8'h0A, 5'h00},
    {8'h45, 2'h0, 8'h05, 5'h00}, {8'h84, 2'h2, 8'h84, 5'h12},
    {8'h20, 2'h1, 8'h20, 5'h09}};
  assign outs = {o_failsafe_low, o_crc_count_clear, o_pixel_gating_by_enable,
    o_legacy_compat_select, o_slow_clock_range_select};
  smsr_top smsr_top_inst (.*);
  initial forever #5 I_CLK = ~I_CLK;
  task cyc;
    @(posedge I_CLK);
    #1;
  endtask
  task chk(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task bus(input logic [7:0] a, input logic [7:0] v, input logic w);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = w;
    i_reg_rd = !w;
    cyc;
    i_reg_wr = 0;
    i_reg_rd = 0;
    cyc;
  endtask
  task finish_test;
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge I_CLK);
    #1 I_RST_N = 1;
    repeat (3) cyc;
    foreach (rows[i]) begin
      {i_legacy_compat_pin, i_clock_range_pin} = rows[i][14:13];
      bus(8'h04, rows[i][22:15], 1);
      repeat (4) cyc;
      chk(outs, rows[i][4:0]);
      bus(8'h04, 8'h00, 0);
      chk(o_reg_rdata, rows[i][12:5]);
    end
    bus(8'h33, 8'h00, 0);
    chk(o_reg_rdata, 8'h00);
    bus(8'h04, 8'h10, 1);
    i_peer_unprotected = 1;
    i_pixel_enable = 0;
    i_pixel_data = 24'h123456;
    repeat (3) cyc;
    chk(o_pixel_data, 24'h000000);
    i_pixel_enable = 1;
    cyc;
    chk(o_pixel_data, 24'h123456);
    i_peer_unprotected = 0;
    i_pixel_enable = 0;
    repeat (2) cyc;
    chk(o_pixel_data, 24'h123456);
    bus(8'h04, 8'h1C, 1);
    cyc;
    chk(o_pixel_data, 24'h000000);
    bus(8'h04, 8'h0C, 1);
    i_peer_unprotected = 1;
    cyc;
    chk(o_pixel_data, 24'h123456);
    i_pixel_enable = 1;
    cyc;
    I_RST_N = 0;
    cyc;
    chk(outs, 5'h10);
    I_RST_N = 1;
    repeat (5) cyc;
    chk(outs, 5'h11);
    bus(8'h04, 8'h00, 0);
    chk(o_reg_rdata, 8'h80);
    finish_test;
  end
endmodule
